// >>> rtl/crs_pkg.sv
package crs_pkg;
    // Operation select for the execution block
    typedef enum logic [4:0] {
        OP_ROTATE_LEFT,
        OP_ROTATE_LEFT_VIA_FLAG,
        OP_ROTATE_RIGHT,
        OP_ROTATE_RIGHT_VIA_FLAG,
        OP_SUBTRACT_WITH_BORROW,
        OP_SUBTRACT,
        OP_FORCE_FLAG_HIGH,
        OP_STORE_ACCUMULATOR,
        OP_COPY_STACK_POINTER,
        OP_NIBBLE_SWAP,
        OP_TRAP,
        OP_TEST_REG_A,
        OP_TEST_REG_B,
        OP_EXCHANGE_WITH_B,
        OP_XOR,
        OP_PERIPHERAL_TOGGLE
    } crs_op_t;

    // Extended addressing modes of the accumulator store
    typedef enum logic [1:0] {
        ADDR_DIRECT,
        ADDR_INDEXED,
        ADDR_INDIRECT
    } crs_amode_t;

    localparam logic [15:0] VECTOR_TOP = 16'hFFFF;
    localparam logic [4:0] TRAP_MAX = 5'h17;
    localparam logic [7:0] SP_RESET = 8'h01;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] DATA_RESET = 8'h00;
endpackage

// >>> rtl/crs_flag_gen.sv
// Negative and zero from an eight-bit value
module crs_flag_gen (
    input wire logic [7:0] value_in,
    output logic neg_out,
    output logic zero_out
);
    // Sign bit and all-zero detect
    assign neg_out = value_in[7];
    assign zero_out = (value_in == 8'h00);
endmodule

// >>> rtl/crs_vector_addr.sv
// Address of one byte of a trap vector pair
module crs_vector_addr (
    input wire logic [4:0] trap_num_in,
    input wire logic low_byte_in,
    output logic [15:0] addr_out
);
    logic [15:0] offset;

    // Trap n pair ends at top minus 2n; high byte sits one below
    always_comb begin
        offset = {10'h000, trap_num_in, 1'b0};
        addr_out = crs_pkg::VECTOR_TOP - offset - {15'h0000, ~low_byte_in};
    end
endmodule

// >>> rtl/crs_exec.sv
// Summary of operation
// - rotate left, bit7 to bit0 and carry
// - rotate left via carry, bit7 to carry
// - rotate right, bit0 to bit7 and carry
// - rotate right via carry, bit0 to carry
// - dest minus src minus one plus carry
// - dest minus src, carry means no borrow
// - set carry, clear negative, set zero
// - store A anywhere, three addressing modes
// - stack pointer into B, flags kept
// - swap nibbles, carry from result bit0
// - trap pushes PC high then low
// - vector high byte at lower address
// - traps 0-3 share interrupt vectors, PC only
// - trap 0 jumps to reset handler only
// - test A or B, clear carry
// - exchange with B, flags from old B
// - xor into destination, clear carry
// - peripheral toggle read-modify-write
// - peripheral read always before write
module crs_exec (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic START_IN,
    input wire crs_pkg::crs_op_t OP_IN,
    input wire crs_pkg::crs_amode_t AMODE_IN,
    input wire logic [7:0] SRC_IN,
    input wire logic [7:0] DST_IN,
    input wire logic [7:0] REG_A_IN,
    input wire logic [7:0] REG_B_IN,
    input wire logic [15:0] ADDR_IN,
    input wire logic [15:0] PAIR_IN,
    input wire logic [4:0] TRAP_NUM_IN,
    input wire logic [7:0] SP_IN,
    input wire logic [15:0] PC_IN,
    input wire logic CARRY_IN,
    input wire logic NEG_IN,
    input wire logic ZERO_IN,
    input wire logic [7:0] MEM_RDATA_IN,
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output logic [7:0] RESULT_OUT,
    output logic RESULT_WE_OUT,
    output logic [7:0] B_RESULT_OUT,
    output logic B_WE_OUT,
    output logic [7:0] SP_OUT,
    output logic [15:0] PC_OUT,
    output logic PC_WE_OUT,
    output logic CARRY_OUT,
    output logic NEG_OUT,
    output logic ZERO_OUT,
    output logic FLAGS_WE_OUT,
    output logic [15:0] MEM_ADDR_OUT,
    output logic [7:0] MEM_WDATA_OUT,
    output logic MEM_RD_OUT,
    output logic MEM_WR_OUT,
    output logic PERIPH_RD_OUT,
    output logic PERIPH_WR_OUT
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH_HIGH,
        ST_PUSH_LOW,
        ST_VEC_HIGH,
        ST_VEC_LOW,
        ST_PER_READ,
        ST_PER_WRITE
    } crs_state_t;

    crs_state_t state_reg, state_next;
    logic busy_reg, busy_next, done_reg, done_next;
    logic result_we_reg, result_we_next, b_we_reg, b_we_next;
    logic pc_we_reg, pc_we_next, flags_we_reg, flags_we_next;
    logic carry_reg, carry_next, neg_reg, neg_next, zero_reg, zero_next;
    logic mem_rd_reg, mem_rd_next, mem_wr_reg, mem_wr_next;
    logic per_rd_reg, per_rd_next, per_wr_reg, per_wr_next;
    logic [7:0] result_reg, result_next, b_result_reg, b_result_next;
    logic [7:0] sp_reg, sp_next, mem_wdata_reg, mem_wdata_next;
    logic [7:0] vec_high_reg, vec_high_next, src_reg, src_next;
    logic [15:0] pc_reg, pc_next, mem_addr_reg, mem_addr_next;
    logic [4:0] trap_reg, trap_next;

    logic [7:0] alu_val, tgl_val;
    logic alu_carry, alu_neg, alu_zero, tgl_neg, tgl_zero, vec_low_sel;
    logic [8:0] diff;
    logic [15:0] vec_addr;

    // Negative and zero of the single-cycle result
    crs_flag_gen u_alu_flags (
        .value_in(alu_val), .neg_out(alu_neg), .zero_out(alu_zero)
    );
    // Negative and zero of the peripheral toggle result
    crs_flag_gen u_tgl_flags (
        .value_in(tgl_val), .neg_out(tgl_neg), .zero_out(tgl_zero)
    );
    // Vector table byte address for the trap in flight
    crs_vector_addr u_vec_addr (
        .trap_num_in(trap_reg), .low_byte_in(vec_low_sel), .addr_out(vec_addr)
    );

    assign tgl_val = MEM_RDATA_IN ^ src_reg;
    assign vec_low_sel = (state_reg == ST_VEC_LOW);

    // Single-cycle data operations
    always_comb begin
        alu_val = DST_IN;
        alu_carry = 1'b0;
        diff = 9'h000;
        unique case (OP_IN)
            crs_pkg::OP_ROTATE_LEFT: begin
                alu_val = {DST_IN[6:0], DST_IN[7]};
                alu_carry = DST_IN[7];
            end
            crs_pkg::OP_ROTATE_LEFT_VIA_FLAG: begin
                alu_val = {DST_IN[6:0], CARRY_IN};
                alu_carry = DST_IN[7];
            end
            crs_pkg::OP_ROTATE_RIGHT: begin
                alu_val = {DST_IN[0], DST_IN[7:1]};
                alu_carry = DST_IN[0];
            end
            crs_pkg::OP_ROTATE_RIGHT_VIA_FLAG: begin
                alu_val = {CARRY_IN, DST_IN[7:1]};
                alu_carry = DST_IN[0];
            end
            crs_pkg::OP_SUBTRACT_WITH_BORROW: begin
                // Borrow shows as bit 8 of the extended difference
                diff = {1'b0, DST_IN} - {1'b0, SRC_IN} - 9'h001
                    + {8'h00, CARRY_IN};
                alu_val = diff[7:0];
                alu_carry = ~diff[8];
            end
            crs_pkg::OP_SUBTRACT: begin
                diff = {1'b0, DST_IN} - {1'b0, SRC_IN};
                alu_val = diff[7:0];
                alu_carry = ~diff[8];
            end
            crs_pkg::OP_FORCE_FLAG_HIGH: begin
                alu_val = 8'h00;
                alu_carry = 1'b1;
            end
            crs_pkg::OP_STORE_ACCUMULATOR: alu_val = REG_A_IN;
            crs_pkg::OP_NIBBLE_SWAP: begin
                alu_val = {DST_IN[3:0], DST_IN[7:4]};
                alu_carry = DST_IN[4];
            end
            crs_pkg::OP_TEST_REG_A: alu_val = REG_A_IN;
            crs_pkg::OP_TEST_REG_B: alu_val = REG_B_IN;
            crs_pkg::OP_EXCHANGE_WITH_B: alu_val = REG_B_IN;
            crs_pkg::OP_XOR: alu_val = SRC_IN ^ DST_IN;
            default: alu_val = DST_IN;
        endcase
    end

    // Sequencer: next values of every output and state
    always_comb begin
        state_next = state_reg;
        busy_next = busy_reg;
        {done_next, result_we_next, b_we_next, pc_we_next} = 4'h0;
        {flags_we_next, mem_rd_next, mem_wr_next} = 3'h0;
        {per_rd_next, per_wr_next} = 2'h0;
        result_next = result_reg;
        b_result_next = b_result_reg;
        sp_next = sp_reg;
        pc_next = pc_reg;
        carry_next = carry_reg;
        neg_next = neg_reg;
        zero_next = zero_reg;
        mem_addr_next = mem_addr_reg;
        mem_wdata_next = mem_wdata_reg;
        trap_next = trap_reg;
        vec_high_next = vec_high_reg;
        src_next = src_reg;
        unique case (state_reg)
            ST_IDLE: begin
                sp_next = SP_IN;
                if (START_IN) begin
                    busy_next = 1'b1;
                    src_next = SRC_IN;
                    // Flags from the ALU unless the operation keeps them
                    carry_next = alu_carry;
                    neg_next = alu_neg;
                    zero_next = alu_zero;
                    unique case (OP_IN)
                        crs_pkg::OP_STORE_ACCUMULATOR: begin
                            // Any byte of the full space
                            unique case (AMODE_IN)
                                crs_pkg::ADDR_INDEXED:
                                    mem_addr_next = ADDR_IN
                                        + {8'h00, REG_B_IN};
                                crs_pkg::ADDR_INDIRECT:
                                    mem_addr_next = PAIR_IN;
                                default:
                                    mem_addr_next = ADDR_IN;
                            endcase
                            mem_wdata_next = REG_A_IN;
                            mem_wr_next = 1'b1;
                            flags_we_next = 1'b1;
                            done_next = 1'b1;
                            busy_next = 1'b0;
                        end
                        crs_pkg::OP_COPY_STACK_POINTER: begin
                            b_result_next = SP_IN;
                            b_we_next = 1'b1;
                            carry_next = CARRY_IN;
                            {neg_next, zero_next} = {NEG_IN, ZERO_IN};
                            done_next = 1'b1;
                            busy_next = 1'b0;
                        end
                        crs_pkg::OP_TRAP: begin
                            // Status kept; no register init even for 0
                            trap_next = (TRAP_NUM_IN > crs_pkg::TRAP_MAX)
                                ? crs_pkg::TRAP_MAX : TRAP_NUM_IN;
                            carry_next = CARRY_IN;
                            {neg_next, zero_next} = {NEG_IN, ZERO_IN};
                            state_next = ST_PUSH_HIGH;
                        end
                        crs_pkg::OP_PERIPHERAL_TOGGLE: begin
                            mem_addr_next = {8'h00, DST_IN};
                            per_rd_next = 1'b1;
                            state_next = ST_PER_READ;
                        end
                        crs_pkg::OP_EXCHANGE_WITH_B: begin
                            result_next = REG_B_IN;
                            result_we_next = 1'b1;
                            b_result_next = DST_IN;
                            b_we_next = 1'b1;
                            flags_we_next = 1'b1;
                            done_next = 1'b1;
                            busy_next = 1'b0;
                        end
                        crs_pkg::OP_TEST_REG_A,
                        crs_pkg::OP_TEST_REG_B,
                        crs_pkg::OP_FORCE_FLAG_HIGH: begin
                            flags_we_next = 1'b1;
                            done_next = 1'b1;
                            busy_next = 1'b0;
                        end
                        default: begin
                            result_next = alu_val;
                            result_we_next = 1'b1;
                            flags_we_next = 1'b1;
                            done_next = 1'b1;
                            busy_next = 1'b0;
                        end
                    endcase
                end
            end
            ST_PUSH_HIGH: begin
                sp_next = sp_reg + 8'h01;
                mem_addr_next = {8'h00, sp_reg + 8'h01};
                mem_wdata_next = PC_IN[15:8];
                mem_wr_next = 1'b1;
                state_next = ST_PUSH_LOW;
            end
            ST_PUSH_LOW: begin
                sp_next = sp_reg + 8'h01;
                mem_addr_next = {8'h00, sp_reg + 8'h01};
                mem_wdata_next = PC_IN[7:0];
                mem_wr_next = 1'b1;
                state_next = ST_VEC_HIGH;
            end
            ST_VEC_HIGH: begin
                mem_addr_next = vec_addr;
                mem_rd_next = 1'b1;
                state_next = ST_VEC_LOW;
            end
            ST_VEC_LOW: begin
                // High byte returned from the lower address
                vec_high_next = MEM_RDATA_IN;
                mem_addr_next = vec_addr;
                mem_rd_next = 1'b1;
                state_next = ST_PER_WRITE;
            end
            ST_PER_READ: begin
                result_next = tgl_val;
                mem_wdata_next = tgl_val;
                {per_wr_next, result_we_next} = 2'h3;
                carry_next = 1'b0;
                {neg_next, zero_next} = {tgl_neg, tgl_zero};
                flags_we_next = 1'b1;
                done_next = 1'b1;
                busy_next = 1'b0;
                state_next = ST_IDLE;
            end
            ST_PER_WRITE: begin
                // Last vector byte arrives; load the PC
                pc_next = {vec_high_reg, MEM_RDATA_IN};
                pc_we_next = 1'b1;
                done_next = 1'b1;
                busy_next = 1'b0;
                state_next = ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state_reg <= ST_IDLE;
            {busy_reg, done_reg, result_we_reg, b_we_reg} <= 4'h0;
            {pc_we_reg, carry_reg, neg_reg, zero_reg} <= 4'h0;
            {flags_we_reg, mem_rd_reg, mem_wr_reg} <= 3'h0;
            {per_rd_reg, per_wr_reg} <= 2'h0;
            {result_reg, b_result_reg} <= {2{crs_pkg::DATA_RESET}};
            {vec_high_reg, src_reg} <= {2{crs_pkg::DATA_RESET}};
            mem_wdata_reg <= crs_pkg::DATA_RESET;
            sp_reg <= crs_pkg::SP_RESET;
            pc_reg <= crs_pkg::PC_RESET;
            mem_addr_reg <= 16'h0000;
            trap_reg <= 5'h00;
        end else begin
            state_reg <= state_next;
            {busy_reg, done_reg} <= {busy_next, done_next};
            {result_we_reg, b_we_reg} <= {result_we_next, b_we_next};
            {pc_we_reg, flags_we_reg} <= {pc_we_next, flags_we_next};
            {carry_reg, neg_reg} <= {carry_next, neg_next};
            {zero_reg, mem_rd_reg} <= {zero_next, mem_rd_next};
            {mem_wr_reg, per_rd_reg} <= {mem_wr_next, per_rd_next};
            per_wr_reg <= per_wr_next;
            {result_reg, b_result_reg} <= {result_next, b_result_next};
            {sp_reg, src_reg} <= {sp_next, src_next};
            {pc_reg, mem_addr_reg} <= {pc_next, mem_addr_next};
            {mem_wdata_reg, vec_high_reg} <= {mem_wdata_next, vec_high_next};
            trap_reg <= trap_next;
        end
    end

    // Outputs straight from flip-flops
    assign {BUSY_OUT, DONE_OUT, RESULT_WE_OUT, B_WE_OUT} =
        {busy_reg, done_reg, result_we_reg, b_we_reg};
    assign {PC_WE_OUT, FLAGS_WE_OUT, MEM_RD_OUT, MEM_WR_OUT} =
        {pc_we_reg, flags_we_reg, mem_rd_reg, mem_wr_reg};
    assign {CARRY_OUT, NEG_OUT, ZERO_OUT} = {carry_reg, neg_reg, zero_reg};
    assign {PERIPH_RD_OUT, PERIPH_WR_OUT} = {per_rd_reg, per_wr_reg};
    assign {RESULT_OUT, B_RESULT_OUT} = {result_reg, b_result_reg};
    assign {SP_OUT, MEM_WDATA_OUT} = {sp_reg, mem_wdata_reg};
    assign {PC_OUT, MEM_ADDR_OUT} = {pc_reg, mem_addr_reg};
endmodule

// >>> tb/crs_exec_props.sv
// Timing and value relations at the ports of the execution block
module crs_exec_props (
    input wire logic CLK_IN, SYS_RST_IN, START_IN, BUSY_OUT, DONE_OUT,
    input wire crs_pkg::crs_op_t OP_IN,
    input wire logic [7:0] SRC_IN, DST_IN, SP_IN, MEM_RDATA_IN,
    input wire logic [15:0] PC_IN, MEM_ADDR_OUT,
    input wire logic [7:0] RESULT_OUT, B_RESULT_OUT, MEM_WDATA_OUT,
    input wire logic RESULT_WE_OUT, B_WE_OUT, PC_WE_OUT, FLAGS_WE_OUT,
    input wire logic CARRY_OUT, NEG_OUT, ZERO_OUT, MEM_RD_OUT, MEM_WR_OUT,
    input wire logic PERIPH_RD_OUT, PERIPH_WR_OUT
);
    logic go;
    logic [7:0] dst_q;
    logic [7:0] src_q;
    logic [7:0] rd_q;
    logic [15:0] a_q;

    // An accepted request
    assign go = START_IN && !BUSY_OUT;

    // Operands and bus values one cycle back
    always_ff @(posedge CLK_IN) begin
        dst_q <= DST_IN;
        src_q <= SRC_IN;
        rd_q <= MEM_RDATA_IN;
        a_q <= MEM_ADDR_OUT;
    end

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    chk_single_done: assert property (
        go && OP_IN != crs_pkg::OP_TRAP
        && OP_IN != crs_pkg::OP_PERIPHERAL_TOGGLE |=> DONE_OUT)
        else $error("single-cycle operation gave no done");
    chk_rotl_value: assert property (
        go && OP_IN == crs_pkg::OP_ROTATE_LEFT |=> RESULT_WE_OUT
        && RESULT_OUT == {dst_q[6:0], dst_q[7]} && CARRY_OUT == dst_q[7])
        else $error("rotate left value wrong");
    chk_rotr_value: assert property (
        go && OP_IN == crs_pkg::OP_ROTATE_RIGHT |=> RESULT_WE_OUT
        && RESULT_OUT == {dst_q[0], dst_q[7:1]} && CARRY_OUT == dst_q[0])
        else $error("rotate right value wrong");
    chk_sub_value: assert property (
        go && OP_IN == crs_pkg::OP_SUBTRACT |=> RESULT_OUT == dst_q - src_q
        && CARRY_OUT == (dst_q >= src_q))
        else $error("difference or no-borrow flag wrong");
    chk_force_flag_high_flags: assert property (
        go && OP_IN == crs_pkg::OP_FORCE_FLAG_HIGH |=> FLAGS_WE_OUT
        && CARRY_OUT && !NEG_OUT && ZERO_OUT && !RESULT_WE_OUT)
        else $error("force flag high wrong");
    chk_sp_copy: assert property (
        go && OP_IN == crs_pkg::OP_COPY_STACK_POINTER |=> B_WE_OUT
        && B_RESULT_OUT == $past(SP_IN) && !FLAGS_WE_OUT)
        else $error("stack pointer copy wrong");
    chk_trap_done: assert property (
        go && OP_IN == crs_pkg::OP_TRAP |-> ##[5:6] (DONE_OUT && PC_WE_OUT))
        else $error("trap did not finish in time");
    chk_trap_flags: assert property (
        go && OP_IN == crs_pkg::OP_TRAP |=> (!FLAGS_WE_OUT) [*5])
        else $error("trap touched the status");
    chk_push_order: assert property (
        $rose(MEM_WR_OUT) && !DONE_OUT |-> MEM_WDATA_OUT == PC_IN[15:8]
        ##1 MEM_WR_OUT && MEM_WDATA_OUT == PC_IN[7:0]
        && MEM_ADDR_OUT == 16'(a_q + 16'h0001))
        else $error("return address push order wrong");
    chk_vector_pair: assert property (
        $rose(MEM_RD_OUT) |-> MEM_ADDR_OUT >= 16'hFFD0 && !MEM_ADDR_OUT[0]
        ##1 MEM_RD_OUT && MEM_ADDR_OUT == 16'(a_q + 16'h0001))
        else $error("vector fetch address wrong");
    chk_periph_rmw: assert property (
        PERIPH_WR_OUT |-> $past(PERIPH_RD_OUT)
        && MEM_ADDR_OUT == $past(MEM_ADDR_OUT))
        else $error("peripheral write without prior read");
    chk_periph_data: assert property (
        PERIPH_WR_OUT |-> MEM_WDATA_OUT == (rd_q ^ $past(SRC_IN, 2))
        && FLAGS_WE_OUT && !CARRY_OUT && RESULT_WE_OUT)
        else $error("peripheral toggle data wrong");
endmodule

bind crs_exec crs_exec_props i_props (.*);

// >>> tb/crs_mem_model.sv
// Memory space and peripheral registers seen by the execution block
module crs_mem_model (
    input wire logic clk_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic prd_in,
    input wire logic pwr_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [65536];
    logic [7:0] periph [256];
    logic [7:0] rdata_reg = 8'h5A;

    // Reads answer within the strobe's own cycle; toggling junk otherwise
    always @(posedge clk_in) begin
        rdata_reg <= ~rdata_reg;
        if (wr_in) begin
            mem[addr_in] <= wdata_in;
        end
        if (pwr_in) begin
            periph[addr_in[7:0]] <= wdata_in;
        end
    end
    assign rdata_out = rd_in ? mem[addr_in]
        : prd_in ? periph[addr_in[7:0]] : rdata_reg;
endmodule

// >>> tb/crs_exec_bench.sv
// Self-checking bench for the execution block
module crs_exec_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        crs_pkg::crs_op_t op;
        logic [7:0] dst, src;
        logic cin;
        logic [7:0] v;
        logic cexp, we;
    } crs_row_t;
    localparam int NROW = 16;
    // Operation, operand, source, carry in, value, carry out, result write
    crs_row_t rows [NROW] = '{
        '{crs_pkg::OP_ROTATE_LEFT, 8'h93, 8'h00, 1'b0, 8'h27, 1'b1, 1'b1},
        '{crs_pkg::OP_ROTATE_LEFT, 8'h00, 8'h00, 1'b1, 8'h00, 1'b0, 1'b1},
        '{crs_pkg::OP_ROTATE_LEFT_VIA_FLAG, 8'h93, 8'h00, 1'b0, 8'h26, 1'b1, 1'b1},
        '{crs_pkg::OP_ROTATE_LEFT_VIA_FLAG, 8'h01, 8'h00, 1'b1, 8'h03, 1'b0, 1'b1},
        '{crs_pkg::OP_ROTATE_RIGHT, 8'h93, 8'h00, 1'b0, 8'hC9, 1'b1, 1'b1},
        '{crs_pkg::OP_ROTATE_RIGHT_VIA_FLAG, 8'h93, 8'h00, 1'b0, 8'h49, 1'b1, 1'b1},
        '{crs_pkg::OP_ROTATE_RIGHT_VIA_FLAG, 8'h00, 8'h00, 1'b1, 8'h80, 1'b0, 1'b1},
        '{crs_pkg::OP_SUBTRACT_WITH_BORROW, 8'h23, 8'h10, 1'b0, 8'h12, 1'b1, 1'b1},
        '{crs_pkg::OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h00, 1'b0, 8'hFF, 1'b0, 1'b1},
        '{crs_pkg::OP_SUBTRACT, 8'h10, 8'h20, 1'b1, 8'hF0, 1'b0, 1'b1},
        '{crs_pkg::OP_SUBTRACT, 8'h20, 8'h20, 1'b0, 8'h00, 1'b1, 1'b1},
        '{crs_pkg::OP_NIBBLE_SWAP, 8'h5A, 8'h00, 1'b0, 8'hA5, 1'b1, 1'b1},
        '{crs_pkg::OP_XOR, 8'hAA, 8'hFF, 1'b1, 8'h55, 1'b0, 1'b1},
        '{crs_pkg::OP_FORCE_FLAG_HIGH, 8'h44, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0},
        '{crs_pkg::OP_TEST_REG_A, 8'h80, 8'h00, 1'b1, 8'h80, 1'b0, 1'b0},
        '{crs_pkg::OP_TEST_REG_B, 8'h00, 8'h00, 1'b1, 8'h00, 1'b0, 1'b0}
    };
    logic clk, rst, start, c_in, n_in, z_in, busy, done, result_we, b_we;
    logic pc_we, carry, neg, zero, flags_we, mem_rd, mem_wr, p_rd, p_wr;
    crs_pkg::crs_op_t op;
    crs_pkg::crs_amode_t amode;
    logic [7:0] src, dst, reg_a, reg_b, sp, rdata, result, b_result;
    logic [7:0] sp_out, mem_wdata;
    logic [15:0] addr, pair, pc, pc_out, mem_addr;
    logic [4:0] trap_num;
    int errors = 0;
    int cmp_count = 0;

    crs_exec i_crs_exec (
        .CLK_IN(clk), .SYS_RST_IN(rst), .START_IN(start), .OP_IN(op),
        .AMODE_IN(amode), .SRC_IN(src), .DST_IN(dst), .REG_A_IN(reg_a),
        .REG_B_IN(reg_b), .ADDR_IN(addr), .PAIR_IN(pair),
        .TRAP_NUM_IN(trap_num), .SP_IN(sp), .PC_IN(pc), .CARRY_IN(c_in),
        .NEG_IN(n_in), .ZERO_IN(z_in), .MEM_RDATA_IN(rdata),
        .BUSY_OUT(busy), .DONE_OUT(done), .RESULT_OUT(result),
        .RESULT_WE_OUT(result_we), .B_RESULT_OUT(b_result), .B_WE_OUT(b_we),
        .SP_OUT(sp_out), .PC_OUT(pc_out), .PC_WE_OUT(pc_we),
        .CARRY_OUT(carry), .NEG_OUT(neg), .ZERO_OUT(zero),
        .FLAGS_WE_OUT(flags_we), .MEM_ADDR_OUT(mem_addr),
        .MEM_WDATA_OUT(mem_wdata), .MEM_RD_OUT(mem_rd), .MEM_WR_OUT(mem_wr),
        .PERIPH_RD_OUT(p_rd), .PERIPH_WR_OUT(p_wr)
    );
    crs_mem_model i_crs_mem_model (
        .clk_in(clk), .rd_in(mem_rd), .wr_in(mem_wr), .prd_in(p_rd),
        .pwr_in(p_wr), .addr_in(mem_addr), .wdata_in(mem_wdata),
        .rdata_out(rdata)
    );

    // Clock of 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Count a comparison and report a mismatch
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        $display("errors %0d, comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Idle cycle, then a one-cycle start pulse ending on a falling edge
    task automatic issue(input crs_pkg::crs_op_t o);
        @(negedge clk);
        op = o;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask

    // Bounded wait for done, noting any status write on the way
    task automatic wait_done(output logic f);
        f = 1'b0;
        for (int k = 0; k < 10 && done !== 1'b1; k++) begin
            if (flags_we === 1'b1) f = 1'b1;
            @(negedge clk);
        end
        if (done !== 1'b1) check(1'b0, "no done");
    endtask

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        logic ok, f;
        logic [7:0] hi, lo;
        logic [15:0] ea;
        int tn [3] = '{0, 3, 23};
        {rst, start, c_in, n_in, z_in} = 5'h10;
        op = crs_pkg::OP_XOR;
        amode = crs_pkg::ADDR_DIRECT;
        {src, dst, reg_a, reg_b, sp} = 40'h0;
        {addr, pair, pc} = 48'h0;
        trap_num = 5'h00;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        check(sp_out === 8'h01 && pc_out === 16'h0000 && done === 1'b0,
            "reset values");
        // Table of single-cycle operations, issued back to back
        for (int i = 0; i < NROW; i++) begin
            op = rows[i].op;
            dst = rows[i].dst;
            src = rows[i].src;
            c_in = rows[i].cin;
            reg_a = rows[i].dst;
            reg_b = rows[i].dst;
            start = 1'b1;
            @(negedge clk);
            ok = result_we === rows[i].we
                && (!rows[i].we || result === rows[i].v);
            check(ok, "row result");
            ok = done === 1'b1 && flags_we === 1'b1
                && carry === rows[i].cexp && neg === rows[i].v[7]
                && zero === (rows[i].v === 8'h00);
            check(ok, "row flags");
        end
        start = 1'b0;
        @(negedge clk);
        // Store in each addressing mode, index sum wraps at the top
        reg_a = 8'h80;
        reg_b = 8'h20;
        addr = 16'hFFF0;
        pair = 16'h4321;
        for (int m = 0; m < 3; m++) begin
            amode = crs_pkg::crs_amode_t'(m);
            ea = (m == 0) ? addr : (m == 1) ? 16'(addr + 16'h0020) : pair;
            issue(crs_pkg::OP_STORE_ACCUMULATOR);
            ok = mem_wr === 1'b1 && mem_addr === ea && mem_wdata === 8'h80
                && flags_we === 1'b1 && carry === 1'b0 && neg === 1'b1;
            check(ok, "store");
        end
        sp = 8'h5C;
        issue(crs_pkg::OP_COPY_STACK_POINTER);
        ok = b_we === 1'b1 && b_result === 8'h5C && flags_we === 1'b0;
        check(ok, "stack pointer copy");
        reg_b = 8'h00;
        dst = 8'h77;
        issue(crs_pkg::OP_EXCHANGE_WITH_B);
        ok = result_we === 1'b1 && result === 8'h00 && b_we === 1'b1
            && b_result === 8'h77 && carry === 1'b0 && zero === 1'b1;
        check(ok, "exchange");
        // Peripheral toggle through the model's register
        i_crs_mem_model.periph[8'h29] = 8'h0F;
        dst = 8'h29;
        src = 8'hFF;
        issue(crs_pkg::OP_PERIPHERAL_TOGGLE);
        wait_done(f);
        ok = result === 8'hF0 && result_we === 1'b1 && neg === 1'b1;
        @(negedge clk);
        check(ok && i_crs_mem_model.periph[8'h29] === 8'hF0, "toggle");
        // Traps at both ends of the table, a refused start while busy
        sp = 8'h30;
        pc = 16'h1234;
        for (int j = 0; j < 3; j++) begin
            hi = 8'hA0 + 8'(tn[j]);
            lo = 8'h30 + 8'(tn[j]);
            i_crs_mem_model.mem[16'hFFFE - 16'(2 * tn[j])] = hi;
            i_crs_mem_model.mem[16'hFFFF - 16'(2 * tn[j])] = lo;
            trap_num = 5'(tn[j]);
            issue(crs_pkg::OP_TRAP);
            issue(crs_pkg::OP_FORCE_FLAG_HIGH);
            wait_done(f);
            ok = pc_we === 1'b1 && pc_out === {hi, lo} && !f
                && flags_we === 1'b0 && sp_out === 8'h32;
            check(ok, "trap vector");
            @(negedge clk);
            ok = i_crs_mem_model.mem[16'h0031] === 8'h12
                && i_crs_mem_model.mem[16'h0032] === 8'h34;
            check(ok, "trap push");
        end
        report_and_stop();
    end
endmodule
